// ---- design/psi_consts.svh ----
`ifndef PSI_CONSTS_SVH
`define PSI_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define PSI_OFS_CTRL        12'h000
`define PSI_OFS_STATUS      12'h004
`define PSI_OFS_CONFIG      12'h008

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PSI_CTRL_ISO_BIT    0
`define PSI_STAT_ISO_BIT    0
`define PSI_STAT_REQ_BIT    1
`define PSI_CFG_DEPTH_LSB   0
`define PSI_CFG_MODE_BIT    3
`define PSI_CFG_ENA_LSB     4

// ----------------------------------------------------------------
// reset values and defaults
// ----------------------------------------------------------------
`define PSI_CTRL_RST        32'h0000_0000
`define PSI_RDATA_RST       32'h0000_0000
`define PSI_SYNC_DEPTH_DEF  0
`define PSI_MAX_DEPTH       6
`define PSI_LITE_DEF        1'h0
`define PSI_SCTRL_DEF       1'h0
`define PSI_SSTAT_DEF       1'h0
`define PSI_WCTRL_DEF       1'h1
`define PSI_WSTAT_DEF       1'h1

`endif

// ---- design/psi_pkg.sv ----
// ----------------------------------------------------------------
// shared types of the partition signal isolator
// ----------------------------------------------------------------
package psi_pkg;

	// direction of a signal as seen from the partition
	typedef enum logic [1:0] {
		PSI_DIR_IN   = 2'h0,
		PSI_DIR_OUT  = 2'h1,
		PSI_DIR_SAME = 2'h2,
		PSI_DIR_REV  = 2'h3
	} psi_dir_t;

	// how the forcing of a signal is built
	typedef enum logic [1:0] {
		PSI_RES_BUFFER = 2'h0,
		PSI_RES_CLKBUF = 2'h1,
		PSI_RES_INFER  = 2'h2
	} psi_res_t;

	// isolation state, one-hot
	typedef enum logic [1:0] {
		PSI_ST_OPEN = 2'b01,
		PSI_ST_ISOL = 2'b10
	} psi_state_t;

	// apb request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} psi_apb_req_t;

	// apb answer to the master
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} psi_apb_rsp_t;

	// one beat of a control or status stream
	typedef struct packed {
		logic       tvalid;
		logic [7:0] tdata;
	} psi_beat_t;

endpackage

// ---- design/psi_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// synchroniser chain, depth zero means a straight wire
// ----------------------------------------------------------------
module psi_sync #(
	parameter int DEPTH = 0,
	parameter int W     = 1
) (
	input  wire logic         core_clk,
	input  wire logic [W-1:0] dIn,
	output logic      [W-1:0] dOut
);
	import psi_pkg::*;

	generate
		if (DEPTH == 0) begin : gWire
			// no crossing: the source shares this clock
			assign dOut = dIn;
		end else begin : gChain
			logic [W-1:0] stage_r [DEPTH];   // flop chain
			logic [W-1:0] stage_nxt [DEPTH]; // next chain values

			// each stage only feeds the next one
			always_comb begin
				stage_nxt[0] = dIn;
				for (int i = 1; i < DEPTH; i++) begin
					stage_nxt[i] = stage_r[i-1];
				end
			end

			// data flops carry no reset, they flush in DEPTH cycles
			always_ff @(posedge core_clk) begin
				stage_r <= stage_nxt;
			end

			assign dOut = stage_r[DEPTH-1];
		end
	endgenerate

endmodule

`default_nettype wire

// ---- design/psi_lane.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// one isolated signal: pass through or force a constant
// ----------------------------------------------------------------
module psi_lane #(
	parameter int                W     = 8,
	parameter psi_pkg::psi_res_t RES   = psi_pkg::PSI_RES_INFER,
	parameter logic              DEC   = 1'h1,
	parameter logic [W-1:0]      VALUE = '0
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         isolate,
	input  wire logic [W-1:0] dIn,
	output logic      [W-1:0] dOut
);
	import psi_pkg::*;

	logic [W-1:0] held_r;   // bits already parked on their value
	logic [W-1:0] held_nxt; // next parked bits
	logic [W-1:0] parked;   // parked bits that still force the output

	// parking lapses the moment isolation drops, not one cycle later,
	// so the lane never stays forced while the status already reads open
	assign parked = held_r & {W{isolate}};

	// a gated bit parks only when its input already equals the value
	always_comb begin
		held_nxt = '0;
		if (isolate) begin
			held_nxt = held_r | ~(dIn ^ VALUE);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			held_r <= '0;
		end else begin
			held_r <= held_nxt;
		end
	end

	// forcing per kind; undecoupled signals ignore isolation
	always_comb begin
		dOut = dIn;
		if (DEC) begin
			case (RES)
				PSI_RES_BUFFER: begin
					// instant switch, may glitch on the way
					dOut = isolate ? VALUE : dIn;
				end
				PSI_RES_CLKBUF: begin
					// parked bits already equal the value: no glitch
					dOut = (VALUE & parked) | (dIn & ~parked);
				end
				default: begin
					// plain mux, one lut per bit
					dOut = isolate ? VALUE : dIn;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// ---- design/psi_isolator.sv ----
`include "psi_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module psi_isolator #(
	parameter int          LANES     = 4,
	parameter int          W         = 32,
	parameter int          VW        = 64,
	parameter int          SYNC_DEPTH = `PSI_SYNC_DEPTH_DEF,
	parameter logic        MODE_SLAVE = 1'h0,
	parameter logic        lite_regs_enable      = `PSI_LITE_DEF,
	parameter logic        stream_control_enable = `PSI_SCTRL_DEF,
	parameter logic        stream_status_enable  = `PSI_SSTAT_DEF,
	parameter logic        wire_control_enable   = `PSI_WCTRL_DEF,
	parameter logic        wire_status_enable    = `PSI_WSTAT_DEF,
	parameter logic [LANES-1:0]   LANE_PRESENT = '1,
	parameter logic [LANES-1:0]   LANE_DEC     = '1,
	parameter logic [LANES-1:0]   LANE_DEF_IN  = '1,
	parameter logic [2*LANES-1:0] LANE_DIR     = {LANES{2'h2}},
	parameter logic [2*LANES-1:0] LANE_RES     = {LANES{2'h2}},
	parameter logic [6*LANES-1:0] LANE_WIDTH   = {LANES{6'h20}},
	parameter logic [VW*LANES-1:0] LANE_VALUE  = '0
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	input  wire psi_pkg::psi_apb_req_t  apbReq,
	output psi_pkg::psi_apb_rsp_t       apbRsp,
	input  wire logic                   isolateReq,
	output logic                        isolateStatus,
	input  wire psi_pkg::psi_beat_t     ctrlBeat,
	output logic                        ctrlReady,
	output psi_pkg::psi_beat_t          statBeat,
	input  wire logic                   statReady,
	input  wire logic [LANES*W-1:0]     staticIn,
	input  wire logic [LANES*W-1:0]     partIn,
	output logic      [LANES*W-1:0]     staticOut,
	output logic      [LANES*W-1:0]     partOut
);
	import psi_pkg::*;

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------

	// mask of the low bits that a signal of this width really has
	function automatic logic [W-1:0] widthMask(input logic [5:0] wid);
		logic [W-1:0] m;
		m = '0;
		for (int b = 0; b < W; b++) begin
			if (b < int'(wid)) begin
				m[b] = 1'h1;
			end
		end
		return m;
	endfunction

	// legal depths are 0 and 2..6; 1 and depths above 6 fall back to none
	function automatic int legalDepth(input int d);
		if (d == 0 || d == 1 || d > `PSI_MAX_DEPTH) begin
			return 0;
		end
		return d;
	endfunction

	// does this signal flow into the partition
	function automatic logic flowsIn(input logic [1:0] dir,
	                                 input logic       defIn);
		logic base;
		base = defIn ^ MODE_SLAVE; // slave mode turns the same and reversed signals
		case (psi_dir_t'(dir))
			PSI_DIR_IN:   flowsIn = 1'h1;
			PSI_DIR_OUT:  flowsIn = 1'h0;
			PSI_DIR_SAME: flowsIn = base;
			default:      flowsIn = ~base;
		endcase
	endfunction

	localparam int DEPTH = legalDepth(SYNC_DEPTH);

	// ----------------------------------------------------------------
	// apb register access
	// ----------------------------------------------------------------
	logic        setupPh;     // setup phase of a transfer
	logic        accessPh;    // access phase of a transfer
	logic        mapped;      // address hits a register
	logic        ctrlBit_r;   // isolate request from software
	logic        ctrlBit_nxt;
	logic [31:0] rdata_r;     // read data captured in setup
	logic [31:0] rdata_nxt;
	logic        err_r;       // error answer captured in setup
	logic        err_nxt;
	psi_state_t  state_r;     // isolation state
	psi_state_t  state_nxt;
	logic        isoReq;      // merged isolate request

	assign setupPh  = apbReq.psel & ~apbReq.penable;
	assign accessPh = apbReq.psel & apbReq.penable;
	assign mapped   = (apbReq.paddr == `PSI_OFS_CTRL) ||
	                  (apbReq.paddr == `PSI_OFS_STATUS) ||
	                  (apbReq.paddr == `PSI_OFS_CONFIG);

	// read data is prepared in setup so that it leaves a flop
	always_comb begin
		rdata_nxt   = rdata_r;
		err_nxt     = err_r;
		ctrlBit_nxt = ctrlBit_r;
		if (setupPh) begin
			rdata_nxt = '0;
			// with the register port absent every access errors
			err_nxt   = ~mapped | ~lite_regs_enable;
			if (lite_regs_enable && !apbReq.pwrite) begin
				case (apbReq.paddr)
					`PSI_OFS_CTRL: begin
						rdata_nxt[`PSI_CTRL_ISO_BIT] = ctrlBit_r;
					end
					`PSI_OFS_STATUS: begin
						rdata_nxt[`PSI_STAT_ISO_BIT] =
							(state_r == PSI_ST_ISOL);
						rdata_nxt[`PSI_STAT_REQ_BIT] = isoReq;
					end
					`PSI_OFS_CONFIG: begin
						rdata_nxt[`PSI_CFG_DEPTH_LSB +: 3] =
							3'(DEPTH);
						rdata_nxt[`PSI_CFG_MODE_BIT] = MODE_SLAVE;
						rdata_nxt[`PSI_CFG_ENA_LSB +: 5] =
							{wire_status_enable, wire_control_enable,
							 stream_status_enable,
							 stream_control_enable, lite_regs_enable};
					end
					default: begin
						rdata_nxt = '0;
					end
				endcase
			end
		end
		// a write lands only on the edge that completes it
		if (accessPh && apbReq.pwrite && lite_regs_enable &&
		    apbReq.paddr == `PSI_OFS_CTRL) begin
			ctrlBit_nxt = apbReq.pwdata[`PSI_CTRL_ISO_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrlBit_r <= 1'(`PSI_CTRL_RST);
			rdata_r   <= `PSI_RDATA_RST;
			err_r     <= 1'h0;
		end else begin
			ctrlBit_r <= ctrlBit_nxt;
			rdata_r   <= rdata_nxt;
			err_r     <= err_nxt;
		end
	end

	// zero wait states: the access phase is always answered at once
	always_comb begin
		apbRsp.pready  = accessPh;
		apbRsp.pslverr = accessPh & err_r;
		apbRsp.prdata  = rdata_r;
	end

	// ----------------------------------------------------------------
	// stream control channel
	// ----------------------------------------------------------------
	logic streamBit_r;   // isolate request from the stream
	logic streamBit_nxt;

	// absent channel never accepts a beat
	assign ctrlReady = stream_control_enable;

	always_comb begin
		streamBit_nxt = streamBit_r;
		if (ctrlBeat.tvalid && stream_control_enable) begin
			streamBit_nxt = ctrlBeat.tdata[0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			streamBit_r <= 1'h0;
		end else begin
			streamBit_r <= streamBit_nxt;
		end
	end

	// ----------------------------------------------------------------
	// isolation state
	// ----------------------------------------------------------------

	// any enabled control source can ask for isolation
	assign isoReq = (wire_control_enable & isolateReq) |
	                (lite_regs_enable & ctrlBit_r) |
	                (stream_control_enable & streamBit_r);

	// two states only; the request is level, so it simply follows
	always_comb begin
		case (state_r)
			PSI_ST_OPEN: state_nxt = isoReq ? PSI_ST_ISOL : PSI_ST_OPEN;
			PSI_ST_ISOL: state_nxt = isoReq ? PSI_ST_ISOL : PSI_ST_OPEN;
			default:     state_nxt = PSI_ST_OPEN;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r <= PSI_ST_OPEN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// status wire follows the state flop; absent means held low
	assign isolateStatus = wire_status_enable &
	                       (state_r == PSI_ST_ISOL);

	// ----------------------------------------------------------------
	// stream status channel
	// ----------------------------------------------------------------
	logic      statValid_r; // a status beat is waiting
	logic      statValid_nxt;
	logic      statIso_r;   // isolation value carried in the beat
	logic      statIso_nxt;
	logic      isoChange;   // state flips this cycle

	assign isoChange = (state_nxt != state_r);

	// a new change wins over the handshake that drains the beat
	always_comb begin
		statValid_nxt = statValid_r;
		statIso_nxt   = statIso_r;
		if (statValid_r && statReady) begin
			statValid_nxt = 1'h0;
		end
		if (isoChange && stream_status_enable) begin
			statValid_nxt = 1'h1;
			statIso_nxt   = (state_nxt == PSI_ST_ISOL);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			statValid_r <= 1'h0;
			statIso_r   <= 1'h0;
		end else begin
			statValid_r <= statValid_nxt;
			statIso_r   <= statIso_nxt;
		end
	end

	always_comb begin
		statBeat.tvalid = statValid_r;
		statBeat.tdata  = {7'h00, statIso_r};
	end

	// ----------------------------------------------------------------
	// signal lanes
	// ----------------------------------------------------------------
	logic laneIso; // isolation as seen by every lane

	assign laneIso = (state_r == PSI_ST_ISOL);

	generate
		for (genvar g = 0; g < LANES; g++) begin : gLane
			localparam logic       TO_PART = flowsIn(
				LANE_DIR[2*g +: 2], LANE_DEF_IN[g]);
			localparam logic [W-1:0] MASK =
				widthMask(LANE_WIDTH[6*g +: 6]);
			// value bits beyond the width are quietly dropped
			localparam logic [W-1:0] VAL =
				LANE_VALUE[VW*g +: W] & MASK;
			logic [W-1:0] src;    // source side of this signal
			logic [W-1:0] synced; // after the crossing stages
			logic [W-1:0] forced; // after isolation

			assign src = (TO_PART ? staticIn[W*g +: W] :
			                        partIn[W*g +: W]) & MASK;

			psi_sync #(
				.DEPTH (DEPTH),
				.W     (W)
			) uSync (
				.core_clk (core_clk),
				.dIn      (src),
				.dOut     (synced)
			);

			psi_lane #(
				.W     (W),
				.RES   (psi_res_t'(LANE_RES[2*g +: 2])),
				.DEC   (LANE_DEC[g]),
				.VALUE (VAL)
			) uLane (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.isolate  (laneIso),
				.dIn      (synced),
				.dOut     (forced)
			);

			// absent signals drive zero and ignore their inputs
			assign partOut[W*g +: W] =
				(LANE_PRESENT[g] && TO_PART) ? forced : '0;
			assign staticOut[W*g +: W] =
				(LANE_PRESENT[g] && !TO_PART) ? forced : '0;
		end
	endgenerate

endmodule

`default_nettype wire

// ---- bench/psi_isolator_checker.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----
// checker, lane values match the bench configuration
// ----
module psi_isolator_checker #(
	parameter int LANES = 6,
	parameter int W     = 8
) (
	input wire logic                  core_clk,
	input wire logic                  rst_n,
	input wire logic                  isolateReq,
	input wire logic                  isolateStatus,
	input wire logic [LANES*W-1:0]    staticIn,
	input wire logic [LANES*W-1:0]    partIn,
	input wire logic [LANES*W-1:0]    staticOut,
	input wire logic [LANES*W-1:0]    partOut
);
	import psi_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// gated lane saw its constant while isolated, still isolated
	sequence parkSeen;
		isolateStatus && staticIn[3*W+:W] == '0 ##1 isolateStatus;
	endsequence

	statusRise_a: assert property ($rose(isolateReq) |=> isolateStatus)
		else $error("status did not follow request");
	statusFall_a: assert property ($fell(isolateStatus) |-> !$past(isolateReq))
		else $error("status dropped while request held");
	inferIso_a: assert property (isolateStatus |-> partOut[0+:W] == 8'hA5)
		else $error("inferred lane constant wrong");
	bufIso_a: assert property (isolateStatus |-> partOut[2*W+:W] == 8'h3C)
		else $error("buffer lane not forced at once");
	revIso_a: assert property (isolateStatus |-> staticOut[4*W+:W] == 8'h5A)
		else $error("reversed lane constant wrong");
	openPass_a: assert property (!isolateStatus |-> partOut[0+:W] == staticIn[0+:W])
		else $error("open lane did not pass");
	keepPass_a: assert property (isolateStatus[*2] |-> staticOut[W+:W] == partIn[W+:W])
		else $error("unisolated lane was forced");
	parkHold_a: assert property (parkSeen |-> partOut[3*W+:W] == '0)
		else $error("gated lane did not park");
	clkSub_a: assert property ((partOut[3*W+:W] & ~staticIn[3*W+:W]) == '0)
		else $error("gated lane showed a bit its input lacks");
	absent_a: assert property (partOut[5*W+:W] == '0 && staticOut[5*W+:W] == '0)
		else $error("absent lane not quiet");
endmodule

bind psi_isolator psi_isolator_checker #(.LANES(LANES), .W(W)) u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .isolateReq(isolateReq),
	.isolateStatus(isolateStatus), .staticIn(staticIn), .partIn(partIn),
	.staticOut(staticOut), .partOut(partOut));

`default_nettype wire

// ---- bench/psi_part_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----
// partition model: drives a counting pattern into the boundary
// ----
module psi_part_model #(
	parameter int LANES = 6,
	parameter int W     = 8
) (
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	input  wire logic [W-1:0]       base,
	output logic      [LANES*W-1:0] partIn
);
	logic [LANES*W-1:0] partInNxt; // next pattern

	// each lane differs, so a swapped lane shows up
	always_comb begin
		for (int g = 0; g < LANES; g++) begin
			partInNxt[g*W+:W] = base + W'(g);
		end
	end

	// partition keeps driving while isolated, it is not told to stop
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			partIn <= '1; // in reset the partition shows junk
		end else begin
			partIn <= partInNxt;
		end
	end
endmodule

`default_nettype wire

// ---- bench/partition_signal_isolator_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module partition_signal_isolator_tb;
	import psi_pkg::*;
	// ----
	// configuration: lane0 in, 1 out unforced, 2 buffer, 3 gated, 4 rev
	// ----
	localparam int LANES = 6;
	localparam int W = 8;
	localparam logic [LANES-1:0] PRES = 6'h1F; // lane5 left out
	localparam logic [LANES-1:0] DEC = 6'h1D; // lane1 passes
	localparam logic [LANES-1:0] INTO = 6'h0D; // flows into partition
	localparam logic [LANES*W-1:0] VALS = 48'h005A_003C_77A5;

	logic               core_clk = 1'h0;
	logic               rst_n = 1'h0;
	psi_apb_req_t       apbReq = '0;
	psi_apb_rsp_t       apbRsp;
	logic               isolateReq = 1'h0;
	logic               isolateStatus;
	logic [LANES*W-1:0] staticIn = '0;
	logic [LANES*W-1:0] partIn, staticOut, partOut;
	logic [W-1:0]       base = 8'h10;
	logic [31:0]        rd;
	logic               ctrlRdy;
	psi_beat_t          ctrlB = '0;
	psi_beat_t          statB;
	logic               err;
	int                 n_mismatch = 0, n_compared = 0, cycles = 0;

	always #4 core_clk = ~core_clk;

	psi_isolator #(.LANES(LANES), .W(W), .lite_regs_enable(1'h1),
		.LANE_PRESENT(PRES), .LANE_DEC(DEC),
		.LANE_DIR({2'h2, 2'h3, 2'h2, 2'h2, 2'h1, 2'h0}),
		.LANE_RES({2'h2, 2'h2, 2'h1, 2'h0, 2'h2, 2'h2}),
		.LANE_WIDTH({LANES{6'h08}}),
		.LANE_VALUE({64'h0, 64'h5A, 64'h0, 64'h3C, 64'h77, 64'h01A5})
	) u_dut (.core_clk(core_clk), .rst_n(rst_n), .apbReq(apbReq),
		.apbRsp(apbRsp), .isolateReq(isolateReq),
		.isolateStatus(isolateStatus), .ctrlBeat(ctrlB), .ctrlReady(ctrlRdy),
		.statBeat(statB), .statReady(1'h1), .staticIn(staticIn),
		.partIn(partIn),
		.staticOut(staticOut), .partOut(partOut));

	psi_part_model #(.LANES(LANES), .W(W)) u_part (.core_clk(core_clk),
		.rst_n(rst_n), .base(base), .partIn(partIn));

	// ----
	// helpers
	// ----
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// let the edge's updates land before looking
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic [11:0] a, input logic wr,
		input logic [31:0] wd);
		@(posedge core_clk);
		apbReq <= '{psel:1'h1, penable:1'h0, pwrite:wr, paddr:a, pwdata:wd};
		@(posedge core_clk);
		apbReq.penable <= 1'h1;
		do @(posedge core_clk); while (apbRsp.pready !== 1'h1);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq <= '0;
	endtask

	// every lane against its expected value; gated lane given by caller
	task automatic lanes(input logic iso, input logic [W-1:0] gated);
		logic [W-1:0] e;
		for (int g = 0; g < LANES; g++) begin
			e = INTO[g] ? staticIn[g*W+:W] : partIn[g*W+:W];
			if (iso && DEC[g]) e = VALS[g*W+:W];
			if (g == 3) e = gated;
			if (!PRES[g]) e = '0;
			check("partOut", 32'(partOut[g*W+:W]), INTO[g] ? 32'(e) : 32'h0);
			check("staticOut", 32'(staticOut[g*W+:W]), INTO[g] ? 32'h0 : 32'(e));
		end
	endtask

	// ceiling well above the roughly fifty cycles the tests need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			summarize();
		end
	end

	// ----
	// tests
	// ----
	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'h1;
		cyc(1);
		check("status", 32'(isolateStatus), 32'h0);
		apb(12'h008, 1'h0, 32'h0);
		check("config", rd, 32'h0000_0190);
		$display("test defaults done");
		@(posedge core_clk);
		staticIn <= 48'h1122_F033_4455;
		base <= 8'h80;
		cyc(2);
		lanes(1'h0, 8'hF0);
		$display("test open done");
		@(posedge core_clk);
		isolateReq <= 1'h1;
		cyc(1);
		check("status", 32'(isolateStatus), 32'h1);
		check("statValid", 32'(statB.tvalid), 32'h0);
		check("ctrlReady", 32'(ctrlRdy), 32'h0);
		lanes(1'h1, 8'hF0);
		apb(12'h004, 1'h0, 32'h0);
		check("statusReg", rd, 32'h0000_0003);
		@(posedge core_clk);
		staticIn[3*W+:W] <= 8'h0F;
		base <= 8'hA0;
		cyc(2);
		lanes(1'h1, 8'h00);
		@(posedge core_clk);
		isolateReq <= 1'h0;
		cyc(1);
		check("status", 32'(isolateStatus), 32'h0);
		lanes(1'h0, 8'h0F);
		$display("test wire isolation done");
		apb(12'h000, 1'h1, 32'h0000_0001);
		cyc(1);
		check("status", 32'(isolateStatus), 32'h1);
		lanes(1'h1, 8'h0F);
		apb(12'h000, 1'h0, 32'h0);
		check("ctrlReg", rd, 32'h0000_0001);
		apb(12'h000, 1'h1, 32'h0);
		cyc(1);
		check("status", 32'(isolateStatus), 32'h0);
		apb(12'h00C, 1'h0, 32'h0);
		check("unmappedErr", 32'(err), 32'h1);
		check("unmappedData", rd, 32'h0);
		apb(12'h004, 1'h1, 32'h0000_0003);
		apb(12'h004, 1'h0, 32'h0);
		check("statusRo", rd, 32'h0);
		ctrlB <= '{tvalid:1'h1, tdata:8'h01};
		cyc(2);
		check("streamCtrl", 32'(isolateStatus), 32'h0);
		$display("test register isolation done");
		summarize();
	end
endmodule

`default_nettype wire
